// [rtl/smcw_top.v]
`timescale 1ns/1ps
`include "smcw_consts.vh"
module smcw_top #(
  parameter [17:0] PULSE_MAX_CYC = `SMCW_PULSE_MAX_CYC,
  parameter [26:0] NREQ_CYC      = `SMCW_NREQ_CYC,
  parameter [26:0] RST_HOLD_CYC  = `SMCW_RST_HOLD_CYC
) (
  input  wire       i_sys_clk,
  input  wire       i_sys_rst,
  input  wire       i_clk_en,
  input  wire       i_can_wu_rx,
  input  wire       i_vsup_below_3v,
  input  wire       i_vsup_below_6v,
  input  wire       i_aux_below_4v5,
  input  wire       i_main_reg_low,
  input  wire       i_chip_select_n,
  input  wire       i_stop_overcur,
  input  wire       i_wd_timeout,
  input  wire       i_wd_closed_trig,
  input  wire       i_wd_cfg,
  input  wire       i_cfg_standby,
  input  wire       i_cmd_normal,
  input  wire       i_cmd_standby,
  input  wire       i_cmd_sleep,
  input  wire       i_cmd_stop,
  input  wire       i_wd_in_stop_en,
  input  wire       i_can_wake_en,
  input  wire       i_can_sleep_cmd,
  input  wire       i_can_normal_cmd,
  input  wire       i_cyclic_wake,
  input  wire       i_forced_wake,
  input  wire       i_early_warn_mask,
  input  wire       i_early_warn_clr,
  input  wire       i_supply_fail_clr,
  output reg  [5:0] o_mode,
  output reg        o_reset_n,
  output reg        o_irq_n_out,
  output reg        o_main_reg_en,
  output reg        o_main_reg_lowpwr,
  output reg        o_aux_ballast_drive,
  output reg        o_osc_lowacc_sel,
  output reg        o_wd_run,
  output reg        o_wd_apply,
  output reg        o_supply_fail_flag,
  output reg        o_low_supply,
  output reg        o_aux_reg_low_flag,
  output reg        o_can_wake_flag,
  output reg        o_can_tx_en,
  output reg        o_can_rx_en,
  output reg        o_can_wake_det_en
);
  localparam [5:0] M_RST   = 6'h01;
  localparam [5:0] M_NREQ  = 6'h02;
  localparam [5:0] M_NORM  = 6'h04;
  localparam [5:0] M_STBY  = 6'h08;
  localparam [5:0] M_SLEEP = 6'h10;
  localparam [5:0] M_STOP  = 6'h20;
  localparam [11:0] IRQ_CYC = `SMCW_IRQ_PULSE_CYC;
  localparam [17:0] PMIN    = `SMCW_PULSE_MIN_CYC;
  localparam [1:0]  NPULSE  = `SMCW_WAKE_PULSES;

  wire [5:0] pins_s;
  wire       rx_s;
  wire       vs3_s;
  wire       vs6_s;
  wire       aux_s;
  wire       mlow_s;
  wire       cs_n_s;
  wire       can_flag;
  wire       can_evt;
  wire       rst_cause;
  wire       dev_wake;
  wire       cs_rise;
  wire       ew_act;
  reg  [5:0]  mode_q;
  reg  [26:0] tm_q;
  reg  [11:0] irq_cnt_q;
  reg         from_sleep_q;
  reg         cs_prev_q;
  reg         can_sleep_q;
  reg         ew_prev_q;
  reg         ew_pend_q;
  reg         wd_apply_q;

  // Pin inputs cross into the clock domain first
  smcw_sync #(
    .W       (6),
    .RST_VAL (`SMCW_SYNC_RST_VAL)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_d       ({i_chip_select_n, i_main_reg_low, i_aux_below_4v5,
                 i_vsup_below_6v, i_vsup_below_3v, i_can_wu_rx}),
    .o_q       (pins_s)
  );

  assign rx_s   = pins_s[0];
  assign vs3_s  = pins_s[1];
  assign vs6_s  = pins_s[2];
  assign aux_s  = pins_s[3];
  assign mlow_s = pins_s[4];
  assign cs_n_s = pins_s[5];

  smcw_can_wake #(
    .CW      (18),
    .MIN_CYC (PMIN),
    .MAX_CYC (PULSE_MAX_CYC),
    .NPULSE  (NPULSE)
  ) u_can_wake (
    .i_sys_clk   (i_sys_clk),
    .i_sys_rst   (i_sys_rst),
    .i_clk_en    (i_clk_en),
    .i_arm       (can_sleep_q & i_can_wake_en),
    .i_rx        (rx_s),
    .o_wake_flag (can_flag),
    .o_wake_evt  (can_evt)
  );

  assign rst_cause = mlow_s | i_wd_timeout | i_wd_closed_trig;
  assign dev_wake  = i_cyclic_wake | i_forced_wake | can_evt;
  assign cs_rise   = ~cs_prev_q & cs_n_s;
  assign ew_act    = (mode_q[`SMCW_M_NORM] | mode_q[`SMCW_M_STBY]) & vs6_s;

  // Mode sequencer
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      mode_q       <= `SMCW_MODE_RST_VAL;
      tm_q         <= 27'h0;
      irq_cnt_q    <= 12'h0;
      from_sleep_q <= 1'b0;
      cs_prev_q    <= 1'b1;
      wd_apply_q   <= 1'b0;
    end else if (i_clk_en) begin
      cs_prev_q  <= cs_n_s;
      wd_apply_q <= 1'b0;
      if (irq_cnt_q != 12'h0) begin
        irq_cnt_q <= irq_cnt_q - 12'h1;
      end
      case (mode_q)
        M_RST: begin
          if (mlow_s) begin
            tm_q <= 27'h0;
          end else if (tm_q >= RST_HOLD_CYC - 27'h1) begin
            tm_q   <= 27'h0;
            mode_q <= M_NREQ;
          end else begin
            tm_q <= tm_q + 27'h1;
          end
        end
        M_NREQ: begin
          if (rst_cause) begin
            tm_q         <= 27'h0;
            from_sleep_q <= 1'b0;
            mode_q       <= M_RST;
          end else if (i_wd_cfg) begin
            tm_q       <= 27'h0;
            wd_apply_q <= 1'b1;
            mode_q     <= i_cfg_standby ? M_STBY : M_NORM;
          end else if (tm_q >= NREQ_CYC - 27'h1) begin
            tm_q <= 27'h0;
            if (from_sleep_q) begin
              mode_q <= M_SLEEP;
            end else begin
              mode_q <= M_RST;
            end
          end else begin
            tm_q <= tm_q + 27'h1;
          end
        end
        M_NORM, M_STBY: begin
          tm_q <= 27'h0;
          if (rst_cause) begin
            from_sleep_q <= 1'b0;
            mode_q       <= M_RST;
          end else if (i_cmd_sleep) begin
            mode_q <= M_SLEEP;
          end else if (i_cmd_stop) begin
            mode_q <= M_STOP;
          end else if (i_cmd_standby) begin
            mode_q <= M_STBY;
          end else if (i_cmd_normal) begin
            mode_q <= M_NORM;
          end
        end
        M_SLEEP: begin
          tm_q <= 27'h0;
          if (dev_wake) begin
            from_sleep_q <= 1'b1;
            mode_q       <= M_RST;
          end
        end
        M_STOP: begin
          tm_q <= 27'h0;
          if (mlow_s || (i_wd_timeout && i_wd_in_stop_en)) begin
            from_sleep_q <= 1'b0;
            mode_q       <= M_RST;
          end else if (dev_wake || i_stop_overcur || cs_rise) begin
            from_sleep_q <= 1'b0;
            irq_cnt_q    <= IRQ_CYC;
            mode_q       <= M_NREQ;
          end
        end
        default: begin
          tm_q   <= 27'h0;
          mode_q <= M_RST;
        end
      endcase
    end
  end

  // CAN interface sleep state
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      can_sleep_q <= 1'b0;
    end else if (i_clk_en) begin
      if (i_can_sleep_cmd || mode_q[`SMCW_M_STBY] || mode_q[`SMCW_M_SLEEP]
          || mode_q[`SMCW_M_STOP]) begin
        can_sleep_q <= 1'b1;
      end else if (i_can_normal_cmd) begin
        can_sleep_q <= 1'b0;
      end
    end
  end

  // Supply monitors and early warning
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ew_prev_q <= 1'b0;
      ew_pend_q <= 1'b0;
    end else if (i_clk_en) begin
      ew_prev_q <= ew_act;
      if (ew_act && !ew_prev_q) begin
        ew_pend_q <= 1'b1;
      end else if (i_early_warn_clr) begin
        ew_pend_q <= 1'b0;
      end
    end
  end

  // Registered outputs
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_mode              <= `SMCW_MODE_RST_VAL;
      o_reset_n           <= 1'b0;
      o_irq_n_out         <= 1'b1;
      o_main_reg_en       <= 1'b1;
      o_main_reg_lowpwr   <= 1'b0;
      o_aux_ballast_drive <= 1'b0;
      o_osc_lowacc_sel    <= 1'b0;
      o_wd_run            <= 1'b0;
      o_wd_apply          <= 1'b0;
      o_supply_fail_flag  <= 1'b0;
      o_low_supply        <= 1'b0;
      o_aux_reg_low_flag  <= 1'b0;
      o_can_wake_flag     <= 1'b0;
      o_can_tx_en         <= 1'b0;
      o_can_rx_en         <= 1'b0;
      o_can_wake_det_en   <= 1'b0;
    end else if (i_clk_en) begin
      o_mode              <= mode_q;
      o_reset_n           <= ~mode_q[`SMCW_M_RST];
      o_irq_n_out         <= ~((irq_cnt_q != 12'h0) | (ew_pend_q & ~i_early_warn_mask));
      o_main_reg_en       <= ~mode_q[`SMCW_M_SLEEP];
      o_main_reg_lowpwr   <= mode_q[`SMCW_M_STOP];
      o_aux_ballast_drive <= mode_q[`SMCW_M_NORM];
      o_osc_lowacc_sel    <= mode_q[`SMCW_M_SLEEP] | mode_q[`SMCW_M_STOP];
      o_wd_run            <= mode_q[`SMCW_M_NORM] | mode_q[`SMCW_M_STBY]
                             | (mode_q[`SMCW_M_STOP] & i_wd_in_stop_en);
      o_wd_apply          <= wd_apply_q;
      o_supply_fail_flag  <= vs3_s | (o_supply_fail_flag & ~i_supply_fail_clr);
      o_low_supply        <= ew_act;
      o_aux_reg_low_flag  <= aux_s;
      o_can_wake_flag     <= can_flag;
      o_can_tx_en         <= ~can_sleep_q & mode_q[`SMCW_M_NORM];
      o_can_rx_en         <= ~can_sleep_q & mode_q[`SMCW_M_NORM];
      o_can_wake_det_en   <= can_sleep_q & i_can_wake_en;
    end
  end
endmodule // smcw_top

// [shared/smcw_consts.vh]
`ifndef SMCW_CONSTS_VH
`define SMCW_CONSTS_VH

// Clock rate
`define SMCW_CLK_MHZ          200
// CAN wake pulse filter
`define SMCW_PULSE_MIN_NS     500
`define SMCW_PULSE_MAX_US     500
`define SMCW_PULSE_MIN_CYC    ((`SMCW_PULSE_MIN_NS * `SMCW_CLK_MHZ + 999) / 1000)
`define SMCW_PULSE_MAX_CYC    (`SMCW_PULSE_MAX_US * `SMCW_CLK_MHZ)
`define SMCW_WAKE_PULSES      3
// Mode timers
`define SMCW_NREQ_MS          350
`define SMCW_NREQ_CYC         (`SMCW_NREQ_MS * 1000 * `SMCW_CLK_MHZ)
`define SMCW_RST_HOLD_US      20
`define SMCW_RST_HOLD_CYC     (`SMCW_RST_HOLD_US * `SMCW_CLK_MHZ)
`define SMCW_IRQ_PULSE_US     10
`define SMCW_IRQ_PULSE_CYC    (`SMCW_IRQ_PULSE_US * `SMCW_CLK_MHZ)
// Mode one-hot bit positions
`define SMCW_M_RST            0
`define SMCW_M_NREQ           1
`define SMCW_M_NORM           2
`define SMCW_M_STBY           3
`define SMCW_M_SLEEP          4
`define SMCW_M_STOP           5
// Reset values
`define SMCW_MODE_RST_VAL     6'h01
`define SMCW_SYNC_RST_VAL     6'h20

`endif

// [rtl/smcw_sync.v]
`timescale 1ns/1ps
module smcw_sync #(
  parameter         W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         i_sys_clk,
  input  wire         i_sys_rst,
  input  wire         i_clk_en,
  input  wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;

  // Two-stage synchroniser; first stage read only by the second
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
    end else if (i_clk_en) begin
      s1_q <= i_d;
      s2_q <= s1_q;
    end
  end

  assign o_q = s2_q;
endmodule // smcw_sync

// [rtl/smcw_can_wake.v]
`timescale 1ns/1ps
module smcw_can_wake #(
  parameter          CW      = 18,
  parameter [CW-1:0] MIN_CYC = 100,
  parameter [CW-1:0] MAX_CYC = 100000,
  parameter [1:0]    NPULSE  = 2'h3
) (
  input  wire i_sys_clk,
  input  wire i_sys_rst,
  input  wire i_clk_en,
  input  wire i_arm,
  input  wire i_rx,
  output reg  o_wake_flag,
  output reg  o_wake_evt
);
  reg          rx_prev_q;
  reg [CW-1:0] wid_q;
  reg [CW-1:0] gap_q;
  reg [1:0]    cnt_q;
  wire         fall;
  wire         accept;
  wire         reject;

  assign fall   = rx_prev_q & ~i_rx;
  assign accept = fall & (wid_q > MIN_CYC) & (wid_q < MAX_CYC);
  assign reject = (fall & ~accept) | (i_rx & (wid_q == MAX_CYC));

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rx_prev_q   <= 1'b0;
      wid_q       <= {CW{1'b0}};
      gap_q       <= {CW{1'b0}};
      cnt_q       <= 2'h0;
      o_wake_flag <= 1'b0;
      o_wake_evt  <= 1'b0;
    end else if (i_clk_en) begin
      if (!i_arm) begin
        // Leaving CAN sleep ends the wake cycle
        rx_prev_q   <= 1'b0;
        wid_q       <= {CW{1'b0}};
        gap_q       <= {CW{1'b0}};
        cnt_q       <= 2'h0;
        o_wake_flag <= 1'b0;
        o_wake_evt  <= 1'b0;
      end else begin
        rx_prev_q  <= i_rx;
        o_wake_evt <= 1'b0;
        if (i_rx && wid_q != MAX_CYC) begin
          wid_q <= wid_q + 1'b1;
        end else if (!i_rx) begin
          wid_q <= {CW{1'b0}};
        end
        if (cnt_q != 2'h0 && !i_rx && gap_q <= MAX_CYC) begin
          gap_q <= gap_q + 1'b1;
        end else if (i_rx || cnt_q == 2'h0) begin
          gap_q <= {CW{1'b0}};
        end
        if (reject) begin
          cnt_q <= 2'h0;
        end else if (gap_q > MAX_CYC) begin
          cnt_q <= 2'h0;
        end else if (accept) begin
          if (cnt_q == NPULSE - 2'h1) begin
            cnt_q       <= 2'h0;
            o_wake_flag <= 1'b1;
            o_wake_evt  <= ~o_wake_flag;
          end else begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
      end
    end
  end
endmodule // smcw_can_wake

// [bench/smcw_properties.sv]
`timescale 1ns/1ps
module smcw_chk (
  input logic       i_sys_clk,
  input logic       i_sys_rst,
  input logic       i_can_normal_cmd,
  input logic [5:0] o_mode,
  input logic       o_reset_n,
  input logic       o_irq_n_out,
  input logic       o_main_reg_en,
  input logic       o_aux_ballast_drive,
  input logic       o_osc_lowacc_sel,
  input logic       o_wd_run,
  input logic       o_wd_apply,
  input logic       o_can_wake_flag,
  input logic       o_can_tx_en,
  input logic       o_can_rx_en,
  input logic       o_can_wake_det_en
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  rst_pin_low_a: assert property (o_mode[0] |-> !o_reset_n)
    else $error("reset output high in reset mode");
  nreq_supply_a: assert property (o_mode[1] |->
    o_main_reg_en && !o_aux_ballast_drive && o_reset_n)
    else $error("normal request supplies wrong");
  norm_supply_a: assert property (o_mode[2] |->
    o_main_reg_en && o_aux_ballast_drive && o_wd_run)
    else $error("normal mode supplies wrong");
  stby_supply_a: assert property (o_mode[3] |->
    o_main_reg_en && !o_aux_ballast_drive && o_wd_run)
    else $error("standby supplies wrong");
  sleep_off_a: assert property (o_mode[4] |-> !o_main_reg_en && o_osc_lowacc_sel)
    else $error("sleep mode supplies wrong");
  fast_osc_a: assert property (|o_mode[3:1] |-> !o_osc_lowacc_sel)
    else $error("low accuracy oscillator in active mode");
  can_quiet_a: assert property (o_can_wake_det_en |-> !o_can_tx_en && !o_can_rx_en)
    else $error("transceiver active in CAN sleep");
  wake_hold_a: assert property ($fell(o_can_wake_flag)
    |-> $past(i_can_normal_cmd, 2) || $past(i_can_normal_cmd, 3))
    else $error("wake flag dropped without CAN normal");
  stop_irq_a: assert property ($rose(o_mode[1]) && $past(o_mode[5]) |-> !o_irq_n_out)
    else $error("no interrupt pulse on stop wake");
  cfg_apply_a: assert property (o_wd_apply |->
    $past(o_mode[1]) && (o_mode[2] || o_mode[3]))
    else $error("watchdog config did not end normal request");
  c_stop_wake: cover property ($rose(o_mode[1]) && $past(o_mode[5]));
  c_can_wake: cover property ($rose(o_can_wake_flag));
  c_sleep: cover property ($rose(o_mode[4]));
endmodule // smcw_chk

bind smcw_top smcw_chk u_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
  .i_can_normal_cmd(i_can_normal_cmd), .o_mode(o_mode), .o_reset_n(o_reset_n),
  .o_irq_n_out(o_irq_n_out), .o_main_reg_en(o_main_reg_en),
  .o_aux_ballast_drive(o_aux_ballast_drive), .o_osc_lowacc_sel(o_osc_lowacc_sel),
  .o_wd_run(o_wd_run), .o_wd_apply(o_wd_apply), .o_can_wake_flag(o_can_wake_flag),
  .o_can_tx_en(o_can_tx_en), .o_can_rx_en(o_can_rx_en),
  .o_can_wake_det_en(o_can_wake_det_en));

// [bench/smcw_can_node.sv]
`timescale 1ns/1ps
module smcw_can_node (
  input  logic i_clk,
  output logic o_rx
);
  initial o_rx = 1'b0;
  // One bus pulse seen by the wake receiver, then idle
  task automatic pulse(input int hi, input int lo);
    @(posedge i_clk) o_rx <= 1'b1;
    repeat (hi) @(posedge i_clk);
    o_rx <= 1'b0;
    repeat (lo) @(posedge i_clk);
  endtask
endmodule // smcw_can_node

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        i_sys_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        ce        = 1'b1;
  logic [13:0] p         = 14'h0000;
  logic [8:0]  l         = 9'h010;
  logic        rx;
  logic [5:0]  o_mode;
  logic [5:0]  last      = 6'h01;
  wire  [5:0]  f;
  logic [5:0]  q[$];
  int          errors    = 0;
  int          n_checks  = 0;
  int          s;
  int          srcs[4]   = '{9, 10, 13, 4};
  int          bad[2]    = '{100, 400};

  initial forever #2.5 i_sys_clk = ~i_sys_clk;

  smcw_can_node node (.i_clk(i_sys_clk), .o_rx(rx));
  smcw_top #(.PULSE_MAX_CYC(18'h00190), .NREQ_CYC(27'h0000fa0), .RST_HOLD_CYC(27'h0000014)) uut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_clk_en(ce), .i_can_wu_rx(rx),
    .i_vsup_below_3v(l[0]), .i_vsup_below_6v(l[1]), .i_aux_below_4v5(l[2]),
    .i_main_reg_low(l[3]), .i_chip_select_n(l[4]), .i_cfg_standby(l[5]),
    .i_wd_in_stop_en(l[6]), .i_can_wake_en(l[7]), .i_early_warn_mask(l[8]),
    .i_wd_timeout(p[0]), .i_wd_closed_trig(p[1]), .i_wd_cfg(p[2]), .i_cmd_normal(p[3]),
    .i_cmd_standby(p[4]), .i_cmd_sleep(p[5]), .i_cmd_stop(p[6]), .i_can_sleep_cmd(p[7]),
    .i_can_normal_cmd(p[8]), .i_cyclic_wake(p[9]), .i_forced_wake(p[10]),
    .i_early_warn_clr(p[11]), .i_supply_fail_clr(p[12]), .i_stop_overcur(p[13]),
    .o_mode(o_mode), .o_reset_n(), .o_irq_n_out(f[0]), .o_main_reg_en(),
    .o_main_reg_lowpwr(f[5]), .o_aux_ballast_drive(), .o_osc_lowacc_sel(), .o_wd_run(),
    .o_wd_apply(), .o_supply_fail_flag(f[2]), .o_low_supply(f[3]),
    .o_aux_reg_low_flag(f[4]), .o_can_wake_flag(f[1]), .o_can_tx_en(), .o_can_rx_en(),
    .o_can_wake_det_en());

  task automatic chk(input logic [5:0] e, input logic [5:0] a);
    n_checks++;
    if (e !== a) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic pl(input int i);
    @(posedge i_sys_clk) p <= 14'h0001 << i;
    @(posedge i_sys_clk) p <= 14'h0000;
  endtask
  task automatic sl(input int i, input logic v);
    @(posedge i_sys_clk) l <= (l & ~(9'h001 << i)) | ({8'h00, v} << i);
  endtask
  task automatic wm(input logic [5:0] m);
    int k;
    for (k = 0; k < 6000 && o_mode !== m; k++) @(negedge i_sys_clk);
    chk(m, o_mode);
  endtask
  task automatic good;
    node.pulse(101 + $urandom % 299, 20 + $urandom % 80);
  endtask
  task automatic flags(input logic [5:0] e);
    cy(8);
    chk(e, {2'h0, f[0], f[2], f[3], f[4]});
  endtask
  task report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Scoreboard: every mode change takes the oldest expected mode
  always @(negedge i_sys_clk) begin
    if (!i_sys_rst && o_mode !== last) begin
      last = o_mode;
      chk(q.size() ? q.pop_front() : 6'h00, o_mode);
    end
  end

  initial begin
    #300000;
    errors++;
    report_and_stop;
  end

  initial begin
    s = $urandom(32'h46e4b5d3);
    q.push_back(6'h02);
    cy(8);
    chk(6'h01, o_mode);
    @(posedge i_sys_clk) i_sys_rst <= 1'b0;
    wm(6'h02);
    @(posedge i_sys_clk) ce <= 1'b0;
    cy(5000);
    chk(6'h02, o_mode);
    @(posedge i_sys_clk) ce <= 1'b1;
    q.push_back(6'h01); q.push_back(6'h02);
    wm(6'h01); wm(6'h02);
    q.push_back(6'h04); pl(2); wm(6'h04);
    pl(7); pl(8);
    sl(0, 1'b1); sl(1, 1'b1); sl(2, 1'b1);
    flags(6'h07);
    @(posedge i_sys_clk) l <= 9'h010;
    flags(6'h04);
    pl(11); pl(12); flags(6'h08);
    sl(8, 1'b1); sl(1, 1'b1); flags(6'h0a);
    sl(1, 1'b0); pl(11); sl(8, 1'b0); flags(6'h08);
    q.push_back(6'h08); pl(4); wm(6'h08);
    q.push_back(6'h04); pl(3); wm(6'h04);
    for (int i = 0; i < 3; i++) begin
      q.push_back(6'h01); q.push_back(6'h02); q.push_back(i == 0 ? 6'h08 : 6'h04);
      if (i < 2) pl(i);
      else begin sl(3, 1'b1); cy(5); sl(3, 1'b0); end
      wm(6'h01); wm(6'h02);
      sl(5, i == 0); pl(2); wm(i == 0 ? 6'h08 : 6'h04);
    end
    sl(7, 1'b1);
    q.push_back(6'h10); pl(5); wm(6'h10);
    foreach (bad[b]) begin
      cy(500); good; good; node.pulse(bad[b], 50); good;
      cy(20); chk(6'h00, {5'h00, f[1]});
    end
    cy(500); good; node.pulse(150, 450); good; good;
    cy(20); chk(6'h00, {5'h00, f[1]});
    sl(7, 1'b0); cy(500); good; good; good;
    cy(20); chk(6'h00, {5'h00, f[1]});
    sl(7, 1'b1); cy(500);
    q.push_back(6'h01); q.push_back(6'h02); q.push_back(6'h10);
    good; good; node.pulse(150, 0);
    wm(6'h01); chk(6'h01, {5'h00, f[1]});
    wm(6'h02); wm(6'h10);
    pl(8); cy(5); chk(6'h01, {5'h00, f[1]});
    q.push_back(6'h01); q.push_back(6'h02); q.push_back(6'h04);
    pl(10); wm(6'h01); wm(6'h02); pl(2); wm(6'h04);
    chk(6'h01, {5'h00, f[1]});
    pl(8); cy(5); chk(6'h00, {5'h00, f[1]});
    foreach (srcs[i]) begin
      q.push_back(6'h20); q.push_back(6'h02); q.push_back(6'h04);
      sl(6, i % 2); pl(6); wm(6'h20);
      chk(6'h01, {5'h00, f[5]});
      if (i < 3) pl(srcs[i]);
      else begin sl(4, 1'b0); cy(3); sl(4, 1'b1); end
      wm(6'h02); chk(6'h00, {5'h00, f[0]});
      cy(1990); chk(6'h00, {5'h00, f[0]});
      cy(20); chk(6'h01, {5'h00, f[0]});
      pl(2); wm(6'h04);
    end
    cy(10);
    chk(6'h00, q.size());
    report_and_stop;
  end
endmodule // tb_top
